// File: common/isz_pkg.sv
// Package: constants and carrier types for the increment-skip-if-zero execution block
package isz_pkg;
  // ----------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------
  localparam logic [5:0] OPCODE_INCSZ  = 6'h0F; // Upper six bits 001111
  localparam int         OPC_MSB       = 15;
  localparam int         OPC_LSB       = 10;
  localparam int         DEST_BIT      = 9;
  localparam int         ACCESS_BIT    = 8;
  localparam logic [3:0] ACCESS_BANK   = 4'h0;  // Bank used when access bit is 0
  localparam logic [7:0] RESULT_RST    = 8'h00;
  localparam logic [3:0] BANK_RST      = 4'h0;
  localparam int         CYCLE_NS      = 4;     // Core clock period
  localparam int         PHASES        = 4;     // Phases per instruction cycle

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ISZ_Q1 = 4'h1,
    ISZ_Q2 = 4'h2,
    ISZ_Q3 = 4'h4,
    ISZ_Q4 = 4'h8
  } isz_phase_t;

  typedef enum logic [2:0] {
    ISZ_EXEC  = 3'h1,
    ISZ_SKIP1 = 3'h2,
    ISZ_SKIP2 = 3'h4
  } isz_cyc_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
  } isz_wr_t;
endpackage : isz_pkg

// File: hdl/isz_phase_gen.sv
// Four-phase instruction-cycle sequencer driven by the core clock
`timescale 1ns/1ps
module isz_phase_gen (
  input  wire logic               clock,
  input  wire logic               srst,
  output isz_pkg::isz_phase_t     phase
);
  // Phase rotation Q1..Q4
  always_ff @(posedge clock) begin
    if (srst) begin
      phase <= isz_pkg::ISZ_Q1;
    end else begin
      case (phase)
        isz_pkg::ISZ_Q1: phase <= isz_pkg::ISZ_Q2;
        isz_pkg::ISZ_Q2: phase <= isz_pkg::ISZ_Q3;
        isz_pkg::ISZ_Q3: phase <= isz_pkg::ISZ_Q4;
        isz_pkg::ISZ_Q4: phase <= isz_pkg::ISZ_Q1;
        default:         phase <= isz_pkg::ISZ_Q1;
      endcase
    end
  end
endmodule : isz_phase_gen

// File: hdl/isz_exec.sv
// Execution unit for the increment-skip-if-zero instruction
//
// Function
// RULE_01: Read the addressed data register, add one, and pass the sum on as the result.
// RULE_02: With destination bit 0 the result goes to the working register only.
// RULE_03: With destination bit 1 the result is written back to the addressed register.
// RULE_04: Skip is true exactly when the 8-bit sum is zero, wrap from 0xFF included.
// RULE_05: On skip, the prefetched next instruction is discarded and a no-op cycle runs.
// RULE_06: One word, one cycle without skip, two cycles with skip.
// RULE_07: Skip over a two-word instruction costs three cycles with two no-op cycles.
// RULE_08: Decode in Q1, read in Q2, process in Q3, write in Q4; skip cycles do nothing.
// RULE_09: Access bit 0 addresses the fixed access bank, ignoring the bank select register.
// RULE_10: Access bit 1 builds the address from the bank select register and file operand.
// RULE_11: Opcode bits 001111 select it, then dest, access and file bits; flags untouched.
`timescale 1ns/1ps
module isz_exec (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             instrValid,    // Instruction word present at Q1
  input  wire logic [15:0]      instrWord,
  input  wire logic             nextIsTwoWord, // Prefetched instruction is two words
  input  wire logic [3:0]       bankSelect,    // Bank select register contents
  input  wire logic [7:0]       regReadData,   // Register file data, valid in Q2
  output isz_pkg::isz_phase_t   phase,
  output logic                  regReadEn,
  output logic [11:0]           regAddr,
  output logic                  regWriteEn,
  output isz_pkg::isz_wr_t      regWrite,
  output logic                  wregWriteEn,
  output logic [7:0]            wregData,
  output logic                  discardFetch,  // Flush prefetched instruction
  output logic                  noOpCycle,     // Current cycle is a no-op cycle
  output logic                  busy,
  output logic                  flagsWriteEn   // Status flags never written
);
  // ----------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------
  function automatic logic isz_match(input logic [15:0] w);
    isz_match = (w[isz_pkg::OPC_MSB:isz_pkg::OPC_LSB] == isz_pkg::OPCODE_INCSZ);
  endfunction : isz_match

  isz_pkg::isz_cyc_t cyc;
  logic              active;
  logic              destReg;
  logic [7:0]        sum;
  logic              skipTaken;
  logic              twoWordSeen;

  isz_phase_gen u_phase (
    .clock (clock),
    .srst  (srst),
    .phase (phase)
  );

  // ----------------------------------------------------------------
  // Decode and address capture in Q1
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      active  <= 1'b0;
      destReg <= 1'b1;
      regAddr <= 12'h000;
    end else if (phase == isz_pkg::ISZ_Q1 && cyc == isz_pkg::ISZ_EXEC) begin
      active  <= instrValid && isz_match(instrWord); // RULE_11
      destReg <= instrWord[isz_pkg::DEST_BIT];
      if (instrWord[isz_pkg::ACCESS_BIT]) begin
        regAddr <= {bankSelect, instrWord[7:0]}; // RULE_10
      end else begin
        regAddr <= {isz_pkg::ACCESS_BANK, instrWord[7:0]}; // RULE_09
      end
    end else if (phase == isz_pkg::ISZ_Q4 && cyc == isz_pkg::ISZ_EXEC) begin
      active <= 1'b0;
    end
  end

  // Register read strobe in Q2
  assign regReadEn = active && phase == isz_pkg::ISZ_Q2; // RULE_08

  // ----------------------------------------------------------------
  // Read and process: capture and increment in Q2
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      sum <= isz_pkg::RESULT_RST;
    end else if (regReadEn) begin
      sum <= regReadData + 8'h01; // RULE_01
    end
  end

  // Skip decision in Q3, wrap to zero included
  always_ff @(posedge clock) begin
    if (srst) begin
      skipTaken   <= 1'b0;
      twoWordSeen <= 1'b0;
    end else if (active && phase == isz_pkg::ISZ_Q3) begin
      skipTaken   <= (sum == 8'h00); // RULE_04
      twoWordSeen <= nextIsTwoWord;
    end else if (phase == isz_pkg::ISZ_Q4 && cyc == isz_pkg::ISZ_EXEC) begin
      skipTaken   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Destination write in Q4
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      regWriteEn  <= 1'b0;
      wregWriteEn <= 1'b0;
      regWrite    <= '0;
      wregData    <= isz_pkg::RESULT_RST;
    end else begin
      regWriteEn  <= active && phase == isz_pkg::ISZ_Q3 && destReg;  // RULE_03
      wregWriteEn <= active && phase == isz_pkg::ISZ_Q3 && !destReg; // RULE_02
      if (active && phase == isz_pkg::ISZ_Q3) begin
        regWrite.addr <= regAddr;
        regWrite.data <= sum;
        wregData      <= sum;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencing: exec, then zero, one or two no-op cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      cyc <= isz_pkg::ISZ_EXEC;
    end else if (phase == isz_pkg::ISZ_Q4) begin
      case (cyc)
        isz_pkg::ISZ_EXEC:  cyc <= skipTaken ? isz_pkg::ISZ_SKIP1 : isz_pkg::ISZ_EXEC; // RULE_06
        isz_pkg::ISZ_SKIP1: cyc <= twoWordSeen ? isz_pkg::ISZ_SKIP2 : isz_pkg::ISZ_EXEC; // RULE_07
        isz_pkg::ISZ_SKIP2: cyc <= isz_pkg::ISZ_EXEC;
        default:            cyc <= isz_pkg::ISZ_EXEC;
      endcase
    end
  end

  // Flush pulse at end of the executing cycle when skipping
  assign discardFetch = skipTaken && cyc == isz_pkg::ISZ_EXEC &&
                        phase == isz_pkg::ISZ_Q4; // RULE_05
  assign noOpCycle    = cyc != isz_pkg::ISZ_EXEC; // RULE_08
  assign busy         = active || noOpCycle;
  assign flagsWriteEn = 1'b0; // RULE_11

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_inc;
    @(posedge clock) disable iff (srst)
      regReadEn |=> sum == $past(regReadData) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("Sum is not read value plus one"); // RULE_01

  property p_wreg;
    @(posedge clock) disable iff (srst)
      wregWriteEn |-> !regWriteEn && phase == isz_pkg::ISZ_Q4;
  endproperty
  a_wreg: assert property (p_wreg) else $error("W write misplaced"); // RULE_02

  // Working register gets the value read two clocks earlier plus one
  property p_wdata;
    @(posedge clock) disable iff (srst)
      wregWriteEn |-> wregData == $past(regReadData, 2) + 8'h01;
  endproperty
  a_wdata: assert property (p_wdata) else $error("W write data wrong"); // RULE_02

  property p_freg;
    @(posedge clock) disable iff (srst)
      regWriteEn |-> regWrite.addr == regAddr &&
                     regWrite.data == $past(regReadData, 2) + 8'h01;
  endproperty
  a_freg: assert property (p_freg) else $error("Register write-back wrong"); // RULE_03

  property p_zero;
    @(posedge clock) disable iff (srst)
      (active && phase == isz_pkg::ISZ_Q3) |=> skipTaken == ($past(regReadData, 2) == 8'hFF);
  endproperty
  a_zero: assert property (p_zero) else $error("Skip decision wrong"); // RULE_04

  property p_flush;
    @(posedge clock) disable iff (srst)
      discardFetch |=> noOpCycle [*4];
  endproperty
  a_flush: assert property (p_flush) else $error("No no-op cycle after flush"); // RULE_05

  property p_one;
    @(posedge clock) disable iff (srst)
      (cyc == isz_pkg::ISZ_EXEC && phase == isz_pkg::ISZ_Q4 && !skipTaken) |=> !noOpCycle;
  endproperty
  a_one: assert property (p_one) else $error("Extra cycle without skip"); // RULE_06

  property p_three;
    @(posedge clock) disable iff (srst)
      (cyc == isz_pkg::ISZ_SKIP1 && phase == isz_pkg::ISZ_Q4 && twoWordSeen)
        |=> cyc == isz_pkg::ISZ_SKIP2 ##4 cyc == isz_pkg::ISZ_EXEC;
  endproperty
  a_three: assert property (p_three) else $error("Two-word skip length wrong"); // RULE_07

  property p_noop;
    @(posedge clock) disable iff (srst)
      noOpCycle |-> !regReadEn && !regWriteEn && !wregWriteEn;
  endproperty
  a_noop: assert property (p_noop) else $error("Activity in a no-op cycle"); // RULE_08

  // Address in Q2 follows the word decoded at the edge ending Q1
  property p_access;
    @(posedge clock) disable iff (srst)
      (regReadEn && !$past(instrWord[isz_pkg::ACCESS_BIT]))
        |-> regAddr == {isz_pkg::ACCESS_BANK, $past(instrWord[7:0])};
  endproperty
  a_access: assert property (p_access) else $error("Access bank address wrong"); // RULE_09

  property p_banked;
    @(posedge clock) disable iff (srst)
      (regReadEn && $past(instrWord[isz_pkg::ACCESS_BIT]))
        |-> regAddr == {$past(bankSelect), $past(instrWord[7:0])};
  endproperty
  a_banked: assert property (p_banked) else $error("Banked address wrong"); // RULE_10

  property p_flags;
    @(posedge clock) disable iff (srst)
      !flagsWriteEn;
  endproperty
  a_flags: assert property (p_flags) else $error("Status flags written"); // RULE_11
endmodule : isz_exec

// File: dv/tb.sv
// Self-checking testbench for the increment-skip-if-zero execution unit
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Signals and scoreboard
  // ----------------------------------------------------------------
  logic                clock, srst, instrValid, nextIsTwoWord;
  logic [15:0]         instrWord;
  logic [3:0]          bankSelect;
  logic [7:0]          regReadData, wregData;
  logic [11:0]         regAddr;
  logic                regReadEn, regWriteEn, wregWriteEn, discardFetch;
  logic                noOpCycle, busy, flagsWriteEn;
  isz_pkg::isz_phase_t phase;
  isz_pkg::isz_wr_t    regWrite;
  logic [20:0]         wrQ[$];
  int                  skipQ[$];
  int                  failCount = 0;
  int                  checksDone = 0;
  int                  noOpRun = 0;
  int                  expSkips = 0;
  int                  discards = 0;
  int unsigned         seedSink, r;

  isz_exec uut (.clock(clock), .srst(srst), .instrValid(instrValid), .instrWord(instrWord),
    .nextIsTwoWord(nextIsTwoWord), .bankSelect(bankSelect), .regReadData(regReadData),
    .phase(phase), .regReadEn(regReadEn), .regAddr(regAddr), .regWriteEn(regWriteEn),
    .regWrite(regWrite), .wregWriteEn(wregWriteEn), .wregData(wregData),
    .discardFetch(discardFetch), .noOpCycle(noOpCycle), .busy(busy),
    .flagsWriteEn(flagsWriteEn));

  // Core clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic cmpWr(input logic [20:0] e, input logic [20:0] g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmpWr

  task automatic cmpInt(input int e, input int g);
    checksDone++;
    if (g != e) begin
      failCount++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmpInt

  task automatic popWr(input logic [20:0] g);
    cmpWr((wrQ.size() != 0) ? wrQ.pop_front() : 21'bx, g);
  endtask : popWr

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : giveVerdict

  // Note expectations, then hold the request until the register read shows up
  task automatic runInstr(input logic dest, input logic acc, input logic two,
                          input logic [7:0] file, input logic [7:0] data,
                          input logic [3:0] bank, input logic [5:0] opc);
    logic [7:0] sum;
    int         n;
    sum = data + 8'h01;
    if (opc == isz_pkg::OPCODE_INCSZ) begin
      wrQ.push_back({dest, (acc ? bank : isz_pkg::ACCESS_BANK), file, sum});
      if (sum == 8'h00) begin
        skipQ.push_back(two ? 8 : 4);
        expSkips++;
      end
    end
    instrWord     <= {opc, dest, acc, file};
    nextIsTwoWord <= two;
    bankSelect    <= bank;
    regReadData   <= data;
    instrValid    <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (regReadEn !== 1'b1 && n < 40);
    if (opc == isz_pkg::OPCODE_INCSZ) cmpInt(1, int'(n < 40));
    // Keep the follower length steady until Q3 has sampled it
    @(posedge clock);
  endtask : runInstr

  // ----------------------------------------------------------------
  // Output monitor: values seen at each edge are those of the ending cycle
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (srst === 1'b0) begin
      if (regWriteEn === 1'b1) popWr({1'b1, regWrite.addr, regWrite.data});
      if (wregWriteEn === 1'b1) popWr({1'b0, regAddr, wregData});
      if (regWriteEn === 1'b1 || wregWriteEn === 1'b1) cmpInt(isz_pkg::ISZ_Q4, phase);
      if (regWriteEn === 1'b1 || noOpCycle === 1'b1) cmpInt(1, int'(busy === 1'b1));
      if (flagsWriteEn !== 1'b0) cmpInt(0, 1);
      if (discardFetch === 1'b1) discards++;
      if (noOpCycle === 1'b1) noOpRun++;
      else if (noOpRun != 0) begin
        cmpInt((skipQ.size() != 0) ? skipQ.pop_front() : -1, noOpRun);
        noOpRun = 0;
      end
    end
  end

  // Watchdog sized well above the expected run of about a thousand ns
  initial begin
    #40000;
    failCount++;
    giveVerdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    nextIsTwoWord = 1'b0;
    bankSelect = 4'h0;
    regReadData = 8'h00;
    seedSink = $urandom(67693);
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    // Wrap to zero for both destinations, both access modes, short and long skips
    for (int i = 0; i < 4; i++) begin
      runInstr(i[0], i[1], i[1], 8'h3C, 8'hFF, 4'hA, isz_pkg::OPCODE_INCSZ);
    end
    $display("test wrap done");
    // A neighbouring opcode must leave everything untouched
    runInstr(1'b1, 1'b1, 1'b0, 8'h55, 8'h12, 4'h5, 6'h0E);
    $display("test foreign opcode done");
    // Random operands back to back, one in four wrapping
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      runInstr(r[0], r[1], r[2], r[15:8], (r[4:3] == 2'b00) ? 8'hFF : r[23:16],
               r[27:24], isz_pkg::OPCODE_INCSZ);
    end
    instrValid <= 1'b0;
    repeat (20) @(posedge clock);
    cmpInt(0, wrQ.size());
    cmpInt(expSkips, discards);
    cmpInt(0, skipQ.size());
    $display("test random done");
    giveVerdict();
  end
endmodule : tb
